// file: hw/chgadc_top.sv
/*
 * Monitoring converter control and result registers of a battery charger.
 * Assumes a converter that takes a one-cycle start with channel and
 * resolution and later answers with a one-cycle done and signed data.
 */
// Function
// - Convert only while converter-on bit set
// - Bit 6: continuous when zero, one-shot when one
// - Bits 5-4 select 15 to 12 bit resolution
// - Bit 3 running average, not for discharge
// - Bit 2 seeds average: old value or fresh
// - Control register resets to 30h
// - First disable register excludes seven channels
// - Second disable register excludes four channels
// - Input current: 16-bit signed, resets zero
// - Input current sign follows flow direction
// - Battery current register at 33h, resets zero
// - Battery current signed, negative when discharging
module chgadc_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        reg_reset_req,
    input  wire logic        wdog_expire,
    output logic             conv_start,
    output logic      [3:0]  conv_channel,
    output logic      [1:0]  conv_resolution,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_data
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  dis0_r, dis0_nxt;
    logic [7:0]  dis1_r, dis1_nxt;
    logic [15:0] icur_r, icur_nxt;
    logic [15:0] bcur_r, bcur_nxt;
    logic [1:0]  live_r, live_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        start_r, start_nxt;
    logic [3:0]  chan_r, chan_nxt;
    logic [3:0]  scan_r, scan_nxt;
    logic [1:0]  res_r, res_nxt;
    chgadc_pkg::chgadc_state_type state_r, state_nxt;

    logic [10:0] off_vec;
    logic        found;
    logic [3:0]  found_idx;
    logic        pass_end;
    logic        ctrl_wr;
    logic        icur_we;
    logic        bcur_we;
    logic        is_bcur;

    chgadc_avg_if avg_bus ();

    chgadc_avg u_avg (
        .av (avg_bus.avg)
    );

    // ------------------------------------------------------------------
    // Channel disable vector and next-channel search
    // ------------------------------------------------------------------
    assign off_vec = {dis1_r[4], dis1_r[5], dis1_r[6], dis1_r[7],
                      dis0_r[1], dis0_r[2], dis0_r[3], dis0_r[4],
                      dis0_r[5], dis0_r[6], dis0_r[7]};

    always_comb begin
        found     = 1'b0;
        found_idx = 4'h0;
        for (int i = chgadc_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (!off_vec[i] && (4'(i) >= scan_r)) begin
                found     = 1'b1;
                found_idx = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        scan_nxt  = scan_r;
        chan_nxt  = chan_r;
        start_nxt = 1'b0;
        res_nxt   = res_r;
        pass_end  = 1'b0;
        icur_we   = 1'b0;
        bcur_we   = 1'b0;
        case (state_r)
            chgadc_pkg::ST_IDLE: begin
                scan_nxt = 4'h0;
                if (ctrl_r[chgadc_pkg::BIT_EN]) begin
                    state_nxt = chgadc_pkg::ST_PICK;
                end
            end
            chgadc_pkg::ST_PICK: begin
                if (!ctrl_r[chgadc_pkg::BIT_EN]) begin
                    state_nxt = chgadc_pkg::ST_IDLE;
                end else if (found) begin
                    start_nxt = 1'b1;
                    chan_nxt  = found_idx;
                    res_nxt   = ctrl_r[chgadc_pkg::RES_HI:chgadc_pkg::RES_LO];
                    state_nxt = chgadc_pkg::ST_WAIT;
                end else begin
                    pass_end = 1'b1;
                    scan_nxt = 4'h0;
                    if (ctrl_r[chgadc_pkg::BIT_ONESHOT]) begin
                        state_nxt = chgadc_pkg::ST_IDLE;
                    end
                end
            end
            chgadc_pkg::ST_WAIT: begin
                if (conv_done) begin
                    icur_we   = (chan_r == chgadc_pkg::CH_ICUR);
                    bcur_we   = (chan_r == chgadc_pkg::CH_BCUR);
                    scan_nxt  = chan_r + 4'h1;
                    state_nxt = chgadc_pkg::ST_PICK;
                end
            end
            default: begin
                state_nxt = chgadc_pkg::ST_IDLE;
            end
        endcase
        if (reg_reset_req) begin
            state_nxt = chgadc_pkg::ST_IDLE;
            start_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= chgadc_pkg::ST_IDLE;
            scan_r  <= 4'h0;
            chan_r  <= 4'h0;
            start_r <= 1'b0;
            res_r   <= chgadc_pkg::RST_CTRL[chgadc_pkg::RES_HI:chgadc_pkg::RES_LO];
        end else begin
            state_r <= state_nxt;
            scan_r  <= scan_nxt;
            chan_r  <= chan_nxt;
            start_r <= start_nxt;
            res_r   <= res_nxt;
        end
    end

    assign conv_start      = start_r;
    assign conv_channel    = chan_r;
    assign conv_resolution = res_r;

    // ------------------------------------------------------------------
    // Averaging and result registers
    // ------------------------------------------------------------------
    assign is_bcur = (chan_r == chgadc_pkg::CH_BCUR);

    always_comb begin
        avg_bus.sample      = conv_data;
        avg_bus.prev        = is_bcur ? bcur_r : icur_r;
        avg_bus.avg_on      = ctrl_r[chgadc_pkg::BIT_AVG];
        avg_bus.fresh_start = ctrl_r[chgadc_pkg::BIT_SEED] && !live_r[is_bcur];
        avg_bus.no_avg      = is_bcur && conv_data[15];
    end

    always_comb begin
        icur_nxt = icur_r;
        bcur_nxt = bcur_r;
        live_nxt = live_r;
        if (icur_we) begin
            icur_nxt    = avg_bus.result;
            live_nxt[0] = 1'b1;
        end
        if (bcur_we) begin
            bcur_nxt    = avg_bus.result;
            live_nxt[1] = 1'b1;
        end
        if (!ctrl_r[chgadc_pkg::BIT_AVG] || !ctrl_r[chgadc_pkg::BIT_EN]) begin
            live_nxt = 2'h0;
        end
        if (reg_reset_req) begin
            icur_nxt = chgadc_pkg::RST_RESULT;
            bcur_nxt = chgadc_pkg::RST_RESULT;
            live_nxt = 2'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            icur_r <= chgadc_pkg::RST_RESULT;
            bcur_r <= chgadc_pkg::RST_RESULT;
            live_r <= 2'h0;
        end else begin
            icur_r <= icur_nxt;
            bcur_r <= bcur_nxt;
            live_r <= live_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    assign ctrl_wr = reg_wr && (reg_addr == chgadc_pkg::OFF_CTRL);

    always_comb begin
        ctrl_nxt = ctrl_r;
        dis0_nxt = dis0_r;
        dis1_nxt = dis1_r;
        if (pass_end && ctrl_r[chgadc_pkg::BIT_ONESHOT]) begin
            ctrl_nxt[chgadc_pkg::BIT_EN] = 1'b0;
        end
        if (wdog_expire) begin
            ctrl_nxt[chgadc_pkg::BIT_EN] = 1'b0;
        end
        if (ctrl_wr) begin
            ctrl_nxt = reg_wdata & chgadc_pkg::MASK_CTRL;
        end else if (reg_wr && (reg_addr == chgadc_pkg::OFF_DIS0)) begin
            dis0_nxt = reg_wdata & chgadc_pkg::MASK_DIS0;
        end else if (reg_wr && (reg_addr == chgadc_pkg::OFF_DIS1)) begin
            dis1_nxt = reg_wdata & chgadc_pkg::MASK_DIS1;
        end
        if (reg_reset_req) begin
            ctrl_nxt = chgadc_pkg::RST_CTRL;
            dis0_nxt = chgadc_pkg::RST_DIS;
            dis1_nxt = chgadc_pkg::RST_DIS;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (!reg_rd) begin
            rdata_nxt = 8'h00;
        end else if (reg_addr == chgadc_pkg::OFF_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (reg_addr == chgadc_pkg::OFF_DIS0) begin
            rdata_nxt = dis0_r;
        end else if (reg_addr == chgadc_pkg::OFF_DIS1) begin
            rdata_nxt = dis1_r;
        end else if (reg_addr == chgadc_pkg::OFF_ICUR_HI) begin
            rdata_nxt = icur_r[15:8];
        end else if (reg_addr == chgadc_pkg::OFF_ICUR_LO) begin
            rdata_nxt = icur_r[7:0];
        end else if (reg_addr == chgadc_pkg::OFF_BCUR_HI) begin
            rdata_nxt = bcur_r[15:8];
        end else if (reg_addr == chgadc_pkg::OFF_BCUR_LO) begin
            rdata_nxt = bcur_r[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r  <= chgadc_pkg::RST_CTRL;
            dis0_r  <= chgadc_pkg::RST_DIS;
            dis1_r  <= chgadc_pkg::RST_DIS;
            rdata_r <= 8'h00;
        end else begin
            ctrl_r  <= ctrl_nxt;
            dis0_r  <= dis0_nxt;
            dis1_r  <= dis1_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_icur_done;
        (state_r == chgadc_pkg::ST_WAIT) && conv_done && (chan_r == chgadc_pkg::CH_ICUR);
    endsequence

    sequence s_bcur_disch;
        (state_r == chgadc_pkg::ST_WAIT) && conv_done && is_bcur && conv_data[15];
    endsequence

    property p_start_needs_en;
        start_nxt |-> ctrl_r[chgadc_pkg::BIT_EN];
    endproperty
    a_start_needs_en: assert property (p_start_needs_en) else $error("start while off");

    property p_continuous;
        (pass_end && !ctrl_r[chgadc_pkg::BIT_ONESHOT] && !wdog_expire && !reg_reset_req
            && !ctrl_wr) |=> ctrl_r[chgadc_pkg::BIT_EN] && (state_r == chgadc_pkg::ST_PICK);
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous mode stopped");

    property p_resolution;
        conv_start |-> conv_resolution == $past(ctrl_r[chgadc_pkg::RES_HI:chgadc_pkg::RES_LO]);
    endproperty
    a_resolution: assert property (p_resolution) else $error("wrong resolution");

    property p_single_value;
        (s_icur_done and !ctrl_r[chgadc_pkg::BIT_AVG] and !reg_reset_req)
            |=> icur_r == $past(conv_data);
    endproperty
    a_single_value: assert property (p_single_value) else $error("single value lost");

    property p_discharge_raw;
        (s_bcur_disch and !reg_reset_req) |=> bcur_r == $past(conv_data);
    endproperty
    a_discharge_raw: assert property (p_discharge_raw) else $error("discharge averaged");

    property p_fresh_seed;
        (s_icur_done and ctrl_r[chgadc_pkg::BIT_SEED] and !live_r[0] and !reg_reset_req)
            |=> icur_r == $past(conv_data);
    endproperty
    a_fresh_seed: assert property (p_fresh_seed) else $error("seed not fresh");

    property p_reset_value;
        $past(reg_reset_req) |-> (ctrl_r == 8'h30) && (icur_r == 16'h0000);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    property p_skip_disabled;
        start_nxt |-> !off_vec[chan_nxt] && (chan_nxt < 4'hB);
    endproperty
    a_skip_disabled: assert property (p_skip_disabled) else $error("disabled channel");

    property p_keep_result;
        (!bcur_we && !reg_reset_req) |=> $stable(bcur_r);
    endproperty
    a_keep_result: assert property (p_keep_result) else $error("result changed");

    property p_oneshot_stop;
        (pass_end && ctrl_r[chgadc_pkg::BIT_ONESHOT] && !ctrl_wr)
            |=> !ctrl_r[chgadc_pkg::BIT_EN] ##1 (state_r == chgadc_pkg::ST_IDLE);
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot not stopped");

    property p_read_hi;
        (reg_rd && (reg_addr == chgadc_pkg::OFF_ICUR_HI)) |=> reg_rdata == $past(icur_r[15:8]);
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("bad read data");

    property p_reserved;
        1'b1 |-> (ctrl_r[1:0] == 2'h0) && (dis0_r[0] == 1'b0) && (dis1_r[3:0] == 4'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule

// file: shared/chgadc_pkg.sv
/*
 * Constants and types of the charger monitoring converter control block.
 * Assumes byte-wide registers at byte offsets on a plain strobe port.
 */
package chgadc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h2E;
    localparam logic [7:0] OFF_DIS0    = 8'h2F;
    localparam logic [7:0] OFF_DIS1    = 8'h30;
    localparam logic [7:0] OFF_ICUR_HI = 8'h31;
    localparam logic [7:0] OFF_ICUR_LO = 8'h32;
    localparam logic [7:0] OFF_BCUR_HI = 8'h33;
    localparam logic [7:0] OFF_BCUR_LO = 8'h34;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL   = 8'h30;
    localparam logic [7:0]  RST_DIS    = 8'h00;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [7:0]  MASK_CTRL  = 8'hFC;
    localparam logic [7:0]  MASK_DIS0  = 8'hFE;
    localparam logic [7:0]  MASK_DIS1  = 8'hF0;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_EN      = 7;
    localparam int unsigned BIT_ONESHOT = 6;
    localparam int unsigned RES_HI      = 5;
    localparam int unsigned RES_LO      = 4;
    localparam int unsigned BIT_AVG     = 3;
    localparam int unsigned BIT_SEED    = 2;

    // ------------------------------------------------------------------
    // Channel numbering, in conversion order
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CH  = 11;
    localparam logic [3:0]  CH_ICUR = 4'h0;
    localparam logic [3:0]  CH_BCUR = 4'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PICK = 2'b01,
        ST_WAIT = 2'b10
    } chgadc_state_type;

endpackage

// file: shared/chgadc_avg_if.sv
/*
 * Carries one sample, the stored value and the averaging controls to the
 * averaging unit and the new result back to the control core.
 */
interface chgadc_avg_if;
    logic [15:0] sample;
    logic [15:0] prev;
    logic        avg_on;
    logic        fresh_start;
    logic        no_avg;
    logic [15:0] result;

    modport core (output sample, output prev, output avg_on, output fresh_start,
                  output no_avg, input result);
    modport avg  (input sample, input prev, input avg_on, input fresh_start,
                  input no_avg, output result);
endinterface

// file: hw/chgadc_avg.sv
/*
 * Running-average unit for signed current readings.
 * Assumes the caller registers the result; this unit is combinational.
 */
module chgadc_avg (
    chgadc_avg_if.avg av
);

    // ------------------------------------------------------------------
    // Average of stored value and new sample, sign kept
    // ------------------------------------------------------------------
    logic [16:0] sum;

    always_comb begin
        sum = {av.prev[15], av.prev} + {av.sample[15], av.sample};
        if (!av.avg_on || av.fresh_start || av.no_avg) begin
            av.result = av.sample;
        end else begin
            av.result = sum[16:1];
        end
    end

endmodule

// file: dv/tb.sv
/*
 * Self-checking bench of the charger monitoring converter control block.
 * Assumes the register port and converter handshake of chgadc_top; the bench
 * drives the converter answer itself.
 */
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_reset_req;
    logic        wdog_expire;
    logic        conv_start;
    logic [3:0]  conv_channel;
    logic [1:0]  conv_resolution;
    logic        conv_done;
    logic [15:0] conv_data;
    int          n_errors;
    int          cmp_count;
    int          n_starts;
    int          cycles;
    int          s;
    logic        pending = 1'b0;
    logic [15:0] ib [4] = '{16'h1388, 16'hFC18, 16'h0002, 16'h0064};
    logic [15:0] bt [4] = '{16'h03E8, 16'hFF38, 16'h0000, 16'h00C8};

    chgadc_top i_dut (
        .mclk            (mclk),
        .rst             (rst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .reg_reset_req   (reg_reset_req),
        .wdog_expire     (wdog_expire),
        .conv_start      (conv_start),
        .conv_channel    (conv_channel),
        .conv_resolution (conv_resolution),
        .conv_done       (conv_done),
        .conv_data       (conv_data)
    );

    // ------------------------------------------------------------------
    // Clock, start counter and hang guard
    // ------------------------------------------------------------------
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (conv_start === 1'b1) begin
            n_starts++;
            pending <= 1'b1;
        end else if (conv_done === 1'b1) begin
            pending <= 1'b0;
        end
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Bus and converter tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic pulse(input int which);
        @(posedge mclk);
        if (which == 0) reg_reset_req <= 1'b1;
        else wdog_expire <= 1'b1;
        @(posedge mclk);
        reg_reset_req <= 1'b0;
        wdog_expire   <= 1'b0;
    endtask

    // Waits for a start, checks its channel and resolution, then answers.
    task automatic convert(input logic [3:0] ch, input logic [1:0] res, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        #1;
        while (conv_start !== 1'b1 && k < 40) begin
            @(posedge mclk);
            #1;
            k++;
        end
        `CHK(conv_start, 1'b1)
        `CHK(conv_channel, ch)
        `CHK(conv_resolution, res)
        @(posedge mclk);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge mclk);
        conv_done <= 1'b0;
        conv_data <= ~d;
    endtask

    // Answers any conversion still outstanding after the converter is stopped.
    task automatic drain();
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (pending === 1'b1) begin
                @(posedge mclk);
                conv_done <= 1'b1;
                conv_data <= 16'hA5A5;
                @(posedge mclk);
                conv_done <= 1'b0;
                conv_data <= 16'h5A5A;
            end
        end
    endtask

    // One-shot pass over the two current channels, then result readback.
    task automatic oneshot(input logic [7:0] c, input logic [15:0] d0, input logic [15:0] d1,
                           input logic [15:0] e0, input logic [15:0] e1);
        int st;
        wr(8'h2E, c);
        convert(4'h0, c[5:4], d0);
        convert(4'h1, c[5:4], d1);
        repeat (4) @(posedge mclk);
        st = n_starts;
        rd(8'h2E, c & 8'h7C);
        `CHK(n_starts, st)
        rd(8'h31, e0[15:8]);
        rd(8'h32, e0[7:0]);
        rd(8'h33, e1[15:8]);
        rd(8'h34, e1[7:0]);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_reset_req = 1'b0;
        wdog_expire = 1'b0;
        conv_done = 1'b0;
        conv_data = 16'h0000;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;

        rd(8'h2E, 8'h30);
        rd(8'h2F, 8'h00);
        rd(8'h30, 8'h00);
        for (int i = 0; i < 4; i++) rd(8'h31 + 8'(i), 8'h00);
        wr(8'h2E, 8'h7F);
        rd(8'h2E, 8'h7C);
        wr(8'h2F, 8'hFF);
        rd(8'h2F, 8'hFE);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'hF0);
        wr(8'h31, 8'h55);
        rd(8'h31, 8'h00);
        wr(8'h40, 8'hAA);
        rd(8'h40, 8'h00);
        s = n_starts;
        repeat (10) @(posedge mclk);
        `CHK(n_starts, s)
        $display("test registers done");

        wr(8'h2F, 8'h3E);
        for (int r = 0; r < 4; r++) oneshot({2'b11, 2'(r), 4'h0}, ib[r], bt[r], ib[r], bt[r]);
        $display("test one-shot resolution done");

        oneshot(8'hC8, 16'h0010, 16'h0004, 16'h003A, 16'h0066);
        oneshot(8'hC8, 16'h0000, 16'hFF38, 16'h001D, 16'hFF38);
        oneshot(8'hCC, 16'h0100, 16'h0010, 16'h0100, 16'h0010);
        $display("test averaging done");

        wr(8'h2F, 8'hBE);
        wr(8'h2E, 8'hC0);
        convert(4'h1, 2'h0, 16'h0222);
        repeat (4) @(posedge mclk);
        rd(8'h2E, 8'h40);
        rd(8'h31, 8'h01);
        rd(8'h32, 8'h00);
        rd(8'h33, 8'h02);
        $display("test channel skip done");

        wr(8'h2F, 8'h3E);
        wr(8'h2E, 8'hA0);
        convert(4'h0, 2'h2, 16'h0011);
        convert(4'h1, 2'h2, 16'h0022);
        convert(4'h0, 2'h2, 16'h0033);
        wr(8'h2E, 8'h00);
        drain();
        rd(8'h2E, 8'h00);
        rd(8'h33, 8'hA5);
        s = n_starts;
        repeat (10) @(posedge mclk);
        `CHK(n_starts, s)
        $display("test continuous done");

        wr(8'h2E, 8'hBC);
        pulse(1);
        drain();
        rd(8'h2E, 8'h3C);
        s = n_starts;
        repeat (10) @(posedge mclk);
        `CHK(n_starts, s)
        $display("test watchdog done");

        pulse(0);
        rd(8'h2E, 8'h30);
        rd(8'h2F, 8'h00);
        rd(8'h31, 8'h00);
        rd(8'h33, 8'h00);
        $display("test register reset done");
        complete_run();
    end
endmodule
